/* core/hbd_top.v */
// drive scheme selection, three phase decoders, readiness and fault flag
`timescale 1ns/1ps
`default_nettype none
`include "hbd_defines.vh"

// scheme decoder for a three-phase bridge driver
// limitations and trade-offs:
// - a scheme change while the bridges switch is not guarded here;
//   the controller is expected to park all phase inputs low first
// - phase outputs lag the inputs by two clocks, one more after a
//   scheme change, traded for flip-flop outputs at this level
// - the strap is read as a settled level, with no debounce window
// - fault causes are kept only on the serial variant
// - a fault forces every bridge to high impedance, whatever the
//   inputs ask for, until the event has gone
module hbd_top #(
	parameter READY_CYC = `HBD_READY_CYC,
	parameter SERIAL_VARIANT = 1
) (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] mode_reg,
	input wire [1:0] mode_strap,
	input wire [2:0] high_side_cmd,
	input wire [2:0] low_side_cmd,
	input wire [`HBD_CAUSE_W-1:0] protect_event,
	input wire cause_clear,
	output reg [2:0] phase_output_drive_q,
	output reg [2:0] phase_output_hiz_q,
	output reg [1:0] scheme_q,
	output reg limit_enable_q,
	output reg sense_amp_output_en_q,
	output reg serial_ready_q,
	output reg fault_flag_n_q,
	output reg [`HBD_CAUSE_W-1:0] fault_cause_q
);
	// counter sized for the full power-up wait at the nominal clock
	localparam CNT_W = 25;
	// last count of the wait, cut to the counter width on purpose
	localparam integer READY_LAST_I = READY_CYC - 1;
	localparam [CNT_W-1:0] READY_LAST = READY_LAST_I[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ZERO = 25'h000_0000;
	localparam [CNT_W-1:0] CNT_ONE = 25'h000_0001;

	// readiness states, one-hot
	localparam [1:0] RDY_WAIT = 2'h1;
	localparam [1:0] RDY_OPEN = 2'h2;

	// true for the two schemes that limit current cycle by cycle
	function scheme_limited;
		input [1:0] code;
		begin
			scheme_limited = (code == `HBD_MODE_6X_LIM) || (code == `HBD_MODE_3X_LIM);
		end
	endfunction

	// scheme source: register on the serial variant, strap on the pin variant
	function [1:0] scheme_pick;
		input serial;
		input [1:0] reg_code;
		input [1:0] strap_code;
		begin
			if (serial)
				scheme_pick = reg_code;
			else
				scheme_pick = strap_code;
		end
	endfunction

	// next sticky cause word; a fresh event always lands, even on a clear
	function [`HBD_CAUSE_W-1:0] cause_next;
		input [`HBD_CAUSE_W-1:0] held;
		input clear;
		input [`HBD_CAUSE_W-1:0] events;
		begin
			if (clear)
				cause_next = events;
			else
				cause_next = held | events;
		end
	endfunction

	reg [1:0] scheme_d;
	reg [CNT_W-1:0] ready_cnt_q;
	reg [CNT_W-1:0] ready_cnt_d;
	reg [1:0] rdy_state_q;
	reg [1:0] rdy_state_d;
	reg ready_d;
	wire [2:0] drv_w;
	wire [2:0] hiz_w;
	wire any_fault;
	assign any_fault = |protect_event;

	// selection source; strap read each cycle as a static level
	always @* begin
		// strap codes already match scheme codes, analog_ground gives 00
		scheme_d = scheme_pick(SERIAL_VARIANT != 0, mode_reg, mode_strap);
	end

	// controller idles inputs before changes, so no glitch guard here
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			scheme_q <= `HBD_MODE_RST;
			limit_enable_q <= 1'b0;
			sense_amp_output_en_q <= 1'b0;
		end else begin
			scheme_q <= scheme_d;
			// limit schemes take the shared pin
			limit_enable_q <= scheme_limited(scheme_d);
			sense_amp_output_en_q <= ~scheme_limited(scheme_d);
		end
	end
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : ph
			hbd_phase_decode u_dec (
				.ref_clk(ref_clk),
				.rst(rst),
				.mode(scheme_q),
				.fault_off(any_fault),
				.high_side_cmd(high_side_cmd[g]),
				.low_side_cmd(low_side_cmd[g]),
				.phase_drive_q(drv_w[g]),
				.phase_hiz_q(hiz_w[g])
			);
		end
	endgenerate
	// retime so outputs leave flip-flops at top level
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_output_drive_q <= 3'h0;
			phase_output_hiz_q <= 3'h7;
		end else begin
			phase_output_drive_q <= drv_w;
			phase_output_hiz_q <= hiz_w;
		end
	end

	// power-up wait, then the serial link stays open until reset
	always @* begin
		rdy_state_d = rdy_state_q;
		ready_cnt_d = ready_cnt_q;
		ready_d = 1'b0;
		case (rdy_state_q)
			RDY_WAIT: begin
				// counter stops once open, so it never wraps on long runs
				ready_cnt_d = ready_cnt_q + CNT_ONE;
				if (ready_cnt_q >= READY_LAST) begin
					rdy_state_d = RDY_OPEN;
					ready_d = 1'b1;
				end
			end
			RDY_OPEN: begin
				ready_d = 1'b1;
			end
			default: begin
				// illegal code: restart the wait rather than open early
				rdy_state_d = RDY_WAIT;
				ready_cnt_d = CNT_ZERO;
			end
		endcase
	end

	// readiness registers; the flag leaves a flip-flop like every output
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdy_state_q <= RDY_WAIT;
			ready_cnt_q <= CNT_ZERO;
			serial_ready_q <= 1'b0;
		end else begin
			rdy_state_q <= rdy_state_d;
			ready_cnt_q <= ready_cnt_d;
			serial_ready_q <= ready_d;
		end
	end

	// fault pin follows any protection event one clock later
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fault_flag_n_q <= 1'b1;
		end else begin
			fault_flag_n_q <= ~any_fault;
		end
	end

	// sticky cause on the serial variant; new events beat the clear
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fault_cause_q <= {`HBD_CAUSE_W{1'b0}};
		end else if (SERIAL_VARIANT != 0) begin
			fault_cause_q <= cause_next(fault_cause_q, cause_clear, protect_event);
		end
	end
endmodule
`default_nettype wire

/* core/hbd_defines.vh */
// constants for the half-bridge drive scheme decoder
`ifndef HBD_DEFINES_VH
`define HBD_DEFINES_VH
`define HBD_MODE_6X 2'h0
`define HBD_MODE_6X_LIM 2'h1
`define HBD_MODE_3X 2'h2
`define HBD_MODE_3X_LIM 2'h3
`define HBD_STRAP_ANALOG_GROUND 2'h0
`define HBD_MODE_RST 2'h0
`define HBD_READY_US 1000
`define HBD_CLK_MHZ 20
`define HBD_READY_CYC (`HBD_READY_US * `HBD_CLK_MHZ)
`define HBD_CAUSE_W 8
`endif

/* core/hbd_phase_decode.v */
// one half-bridge command decoder, registered
`timescale 1ns/1ps
`default_nettype none
`include "hbd_defines.vh"
module hbd_phase_decode (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] mode,
	input wire fault_off,
	input wire high_side_cmd,
	input wire low_side_cmd,
	output reg phase_drive_q,
	output reg phase_hiz_q
);
	reg drive_d;
	reg hiz_d;
	// pure level decode, nothing carried across pwm periods
	always @* begin
		drive_d = 1'b0;
		hiz_d = 1'b1;
		case (mode)
			`HBD_MODE_6X, `HBD_MODE_6X_LIM: begin
				hiz_d = (high_side_cmd == low_side_cmd);
				drive_d = high_side_cmd & ~low_side_cmd;
			end
			default: begin
				hiz_d = ~low_side_cmd;
				drive_d = low_side_cmd & high_side_cmd;
			end
		endcase
		// protection forces the bridge off
		if (fault_off) begin
			hiz_d = 1'b1;
			drive_d = 1'b0;
		end
	end
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_drive_q <= 1'b0;
			phase_hiz_q <= 1'b1;
		end else begin
			phase_drive_q <= drive_d;
			phase_hiz_q <= hiz_d;
		end
	end
endmodule
`default_nettype wire

/* testbench/hbd_checker.sv */
// port assertions for the drive scheme decoder
`timescale 1ns/1ps
`default_nettype none
module hbd_checker #(parameter READY_CYC = 20, parameter SERIAL_VARIANT = 1) (
	input wire ref_clk,
	input wire rst,
	input wire [1:0] mode_reg,
	input wire [1:0] mode_strap,
	input wire [2:0] high_side_cmd,
	input wire [2:0] low_side_cmd,
	input wire [7:0] protect_event,
	input wire [2:0] phase_output_drive_q,
	input wire [2:0] phase_output_hiz_q,
	input wire [1:0] scheme_q,
	input wire limit_enable_q,
	input wire sense_amp_output_en_q,
	input wire serial_ready_q,
	input wire fault_flag_n_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	int cnt_q;
	// age since release, saturating so it never wraps
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			cnt_q <= 0;
		else if (cnt_q < READY_CYC)
			cnt_q <= cnt_q + 1;
	end
	scheme_map_a: assert property (
		!$past(rst) |-> scheme_q == $past(SERIAL_VARIANT != 0 ? mode_reg : mode_strap)) else $error("scheme");
	limit_sel_a: assert property (
		!$past(rst) |-> limit_enable_q == scheme_q[0] && sense_amp_output_en_q != scheme_q[0]) else $error("limit");
	six_hiz_a: assert property (
		!$past(rst, 2) && $past(fault_flag_n_q) && scheme_q == 0 && $past(scheme_q, 2) == 0
		|-> phase_output_hiz_q == ~($past(high_side_cmd, 2) ^ $past(low_side_cmd, 2))) else $error("six");
	three_hiz_a: assert property (
		!$past(rst, 2) && $past(fault_flag_n_q) && scheme_q[1] && $past(scheme_q[1], 2)
		|-> phase_output_hiz_q == ~$past(low_side_cmd, 2)) else $error("three");
	drive_level_a: assert property (
		!$past(rst, 2) && !$past(rst) |-> (phase_output_drive_q | phase_output_hiz_q)
		== ($past(high_side_cmd, 2) | phase_output_hiz_q)) else $error("drive");
	fault_flag_a: assert property (
		!$past(rst) |-> fault_flag_n_q == ($past(protect_event) == 0)) else $error("fault");
	fault_hiz_a: assert property (
		!$past(rst) && !$past(fault_flag_n_q) |-> phase_output_hiz_q == 3'h7) else $error("fault hiz");
	ready_time_a: assert property (
		cnt_q >= READY_CYC |-> serial_ready_q) else $error("ready");
	ready_early_a: assert property (
		cnt_q < READY_CYC |-> !serial_ready_q) else $error("ready early");
endmodule
bind hbd_top hbd_checker #(.READY_CYC(READY_CYC), .SERIAL_VARIANT(SERIAL_VARIANT)) chk_u (.*);
`default_nettype wire

/* testbench/hbd_mcu_model.sv */
// controller model driving the phase commands
`timescale 1ns/1ps
`default_nettype none
module hbd_mcu_model (
	input wire ref_clk,
	output logic [2:0] high_side_cmd,
	output logic [2:0] low_side_cmd
);
	initial {high_side_cmd, low_side_cmd} = 6'h00;
	// levels change on the falling edge, clear of sampling
	task automatic apply(input logic [5:0] hl);
		@(negedge ref_clk);
		{high_side_cmd, low_side_cmd} = hl;
	endtask
endmodule
`default_nettype wire

/* testbench/half_bridge_pwm_mode_decoder_tb.sv */
// bench for the drive scheme decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("ERROR %s %h %h", n, e, g); end end
module half_bridge_pwm_mode_decoder_tb;
	logic ref_clk = 0, rst = 1, cause_clear = 0;
	logic [1:0] mode_reg = 2'h0;
	logic [7:0] protect_event = 8'h00;
	wire [2:0] high_side_cmd, low_side_cmd, phase_output_drive_q, phase_output_hiz_q;
	wire [1:0] scheme_q;
	wire limit_enable_q, sense_amp_output_en_q, serial_ready_q, fault_flag_n_q;
	wire [7:0] fault_cause_q, hw_cause_q;
	wire [1:0] hw_scheme_q;
	int n_errors = 0, samples_checked = 0;
	always #25 ref_clk = ~ref_clk;
	hbd_mcu_model mcu_u (.*);
	// short ready count keeps the run brief
	hbd_top #(.READY_CYC(20)) dut_u (.mode_strap(2'h0), .*);
	// pin variant with the strap at analog ground
	hbd_top #(.READY_CYC(20), .SERIAL_VARIANT(0)) hw_dut_u (
		.ref_clk(ref_clk),
		.rst(rst),
		.mode_reg(mode_reg),
		.mode_strap(2'h0),
		.high_side_cmd(high_side_cmd),
		.low_side_cmd(low_side_cmd),
		.protect_event(protect_event),
		.cause_clear(cause_clear),
		.phase_output_drive_q(),
		.phase_output_hiz_q(),
		.scheme_q(hw_scheme_q),
		.limit_enable_q(),
		.sense_amp_output_en_q(),
		.serial_ready_q(),
		.fault_flag_n_q(),
		.fault_cause_q(hw_cause_q)
	);
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_ready();
		repeat (18) @(negedge ref_clk);
		`CHK("early", 1'b0, serial_ready_q)
		repeat (2) @(negedge ref_clk);
		`CHK("ready", 1'b1, serial_ready_q)
	endtask
	task automatic t_scheme(input logic [1:0] m);
		logic [2:0] hiz_x;
		mcu_u.apply(6'h00);
		@(negedge ref_clk);
		mode_reg = m;
		repeat (3) @(negedge ref_clk);
		`CHK("scheme", m, scheme_q)
		`CHK("limit", m[0], limit_enable_q)
		`CHK("sense", ~m[0], sense_amp_output_en_q)
		for (int i = 0; i < 64; i++) begin
			mcu_u.apply(i[5:0]);
			repeat (2) @(negedge ref_clk);
			hiz_x = m[1] ? ~i[2:0] : ~(i[5:3] ^ i[2:0]);
			`CHK("hiz", hiz_x, phase_output_hiz_q)
			`CHK("drive", i[5:3] | hiz_x, phase_output_drive_q | phase_output_hiz_q)
		end
	endtask
	// mid-run reset: reset levels, then the ready wait again
	task automatic t_reset();
		rst = 1;
		@(negedge ref_clk);
		`CHK("rst hiz", 3'h7, phase_output_hiz_q)
		`CHK("rst fault", 1'b1, fault_flag_n_q)
		`CHK("rst ready", 1'b0, serial_ready_q)
		@(negedge ref_clk);
		rst = 0;
		t_ready();
	endtask
	task automatic t_fault();
		protect_event = 8'h05;
		repeat (3) @(negedge ref_clk);
		`CHK("fault", 1'b0, fault_flag_n_q)
		protect_event = 8'h00;
		repeat (2) @(negedge ref_clk);
		`CHK("cause", 8'h05, fault_cause_q)
		cause_clear = 1;
		repeat (2) @(negedge ref_clk);
		`CHK("clear", 8'h00, fault_cause_q)
		protect_event = 8'h02;
		@(negedge ref_clk);
		`CHK("set wins", 8'h02, fault_cause_q)
		`CHK("hw cause", 8'h00, hw_cause_q)
		`CHK("strap", 2'h0, hw_scheme_q)
		protect_event = 8'h00;
		cause_clear = 0;
	endtask
	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 0;
		t_ready();
		for (int m = 0; m < 4; m++)
			t_scheme(m[1:0]);
		t_fault();
		t_reset();
		close_out();
	end
	// watchdog: about 800 cycles expected
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
endmodule
`default_nettype wire
